/* File: verilog/serial_fram_pkg.sv */
// Constants and types shared by the two-wire serial memory slave
`default_nettype none
package serial_fram_pkg;

  // ==========================================================================
  // Array shape
  localparam int          MEM_DEPTH   = 131072;
  localparam int          ADDR_W      = 17;
  localparam int          DATA_W      = 8;

  // ==========================================================================
  // Slave address byte layout
  localparam logic [3:0]  SLAVE_TYPE  = 4'ha;
  localparam int          TYPE_MSB    = 7;
  localparam int          TYPE_LSB    = 4;
  localparam int          SEL_MSB     = 3;
  localparam int          SEL_LSB     = 2;
  localparam int          PAGE_BIT    = 1;
  localparam int          RW_BIT      = 0;

  // ==========================================================================
  // Bit counter marks: first and eighth data bit and the acknowledge clock
  localparam logic [3:0]  BIT_FIRST   = 4'h0;
  localparam logic [3:0]  BIT_LAST    = 4'h7;
  localparam logic [3:0]  BIT_ACK     = 4'h8;

  // ==========================================================================
  // Timing: shortest pulse accepted on the bus pins
  localparam int          CORE_CLK_MHZ = 50;
  localparam int          GLITCH_NS    = 50;
  localparam int          GLITCH_CYC   = (GLITCH_NS * CORE_CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Protocol states
  typedef enum logic [6:0]
  {
    ST_IDLE   = 7'h01,
    ST_SLAVE  = 7'h02,
    ST_ADDRHI = 7'h04,
    ST_ADDRLO = 7'h08,
    ST_WRITE  = 7'h10,
    ST_READ   = 7'h20,
    ST_IGNORE = 7'h40
  } state_t;

endpackage
`default_nettype wire

/* File: verilog/glitch_filter.sv */
// Pin synchroniser and glitch filter with edge pulses
`timescale 1ns/100ps
`default_nettype none
module glitch_filter
  import serial_fram_pkg::*;
#(
  parameter int       FILTER_LEN  = GLITCH_CYC,
  parameter logic     RESET_LEVEL = 1'b1
)
(
  input  wire logic   core_clk,
  input  wire logic   reset,
  input  wire logic   pinIn,
  output logic        level,
  output logic        rise,
  output logic        fall
);

  // ==========================================================================
  // State
  logic               syncFirst;
  logic               syncSecond;
  logic [7:0]         count;
  logic               next_level;
  logic [7:0]         next_count;
  logic               next_rise;
  logic               next_fall;

  // A new level is taken only after it held for FILTER_LEN cycles
  always_comb
  begin
    next_level = level;
    next_count = 8'h00;
    next_rise  = 1'b0;
    next_fall  = 1'b0;
    if (syncSecond != level)
    begin
      if (count >= 8'(FILTER_LEN - 1))
      begin
        next_level = syncSecond;
        next_rise  = syncSecond;
        next_fall  = !syncSecond;
      end
      else
      begin
        next_count = count + 8'h01;
      end
    end
  end

  // First flop feeds only the second one
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      syncFirst  <= RESET_LEVEL;
      syncSecond <= RESET_LEVEL;
      level      <= RESET_LEVEL;
      count      <= 8'h00;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end
    else
    begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      level      <= next_level;
      count      <= next_count;
      rise       <= next_rise;
      fall       <= next_fall;
    end
  end

  a_filter_stable: assert property (@(posedge core_clk) disable iff (reset)
    (level != $past(level))
    |-> ($past(syncSecond, 1) == level && $past(count) >= 8'(FILTER_LEN - 1)))
    else $error("filtered level changed before input was stable");

endmodule
`default_nettype wire

/* File: verilog/serial_fram_slave.sv */
// Two-wire serial slave front end with its byte array
`timescale 1ns/100ps
`default_nettype none
module serial_fram_slave
  import serial_fram_pkg::*;
#(
  parameter int           DEPTH      = MEM_DEPTH,
  parameter int           FILTER_LEN = GLITCH_CYC,
  parameter logic [23:0]  DEVICE_ID  = 24'h5a_3c_01  // Arbitrary value
)
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        serialClk,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [1:0]  device_select_pins,
  input  wire logic        writeProtect,
  output logic [23:0]      deviceId
);

  // ==========================================================================
  // Declarations
  state_t                  state;
  state_t                  next_state;
  logic [3:0]              bitCnt;
  logic [3:0]              next_bitCnt;
  logic [DATA_W-1:0]       rxShift;
  logic [DATA_W-1:0]       next_rxShift;
  logic [DATA_W-1:0]       txShift;
  logic [DATA_W-1:0]       next_txShift;
  logic [ADDR_W-1:0]       addr;
  logic [ADDR_W-1:0]       next_addr;
  logic [DATA_W-1:0]       addrHi;
  logic [DATA_W-1:0]       next_addrHi;
  logic                    page;
  logic                    next_page;
  logic                    firstRead;
  logic                    next_firstRead;
  logic                    drive;
  logic                    next_drive;
  logic                    driveEnable;
  logic                    next_driveEnable;
  logic                    memWe;
  logic [DATA_W-1:0]       readData;
  logic [DATA_W-1:0]       mem [0:DEPTH-1];
  logic [2:0]              pinSyncA;
  logic [2:0]              pinSyncB;
  logic [1:0]              selSync;
  logic                    wpSync;
  logic                    sclLevel;
  logic                    sclRise;
  logic                    sdaLevel;
  logic                    sdaRise;
  logic                    sdaFall;
  logic                    startSeen;
  logic                    stopSeen;
  logic                    active;
  logic                    byteDone;
  logic                    ackClock;
  logic [DATA_W-1:0]       rxByte;
  logic                    linkPull;

  // ==========================================================================
  // Pin conditioning
  // Filter delay eats into the clock high time; keep it short for the fast rates
  glitch_filter #(.FILTER_LEN(FILTER_LEN), .RESET_LEVEL(1'b1)) sclFilter
  (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    (sclIn),
    .level    (sclLevel),
    .rise     (sclRise),
    .fall     ()
  );

  glitch_filter #(.FILTER_LEN(FILTER_LEN), .RESET_LEVEL(1'b1)) sdaFilter
  (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    (sdaIn),
    .level    (sdaLevel),
    .rise     (sdaRise),
    .fall     (sdaFall)
  );

  // Static straps; the pad pull-downs keep open pins low, as does reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pinSyncA <= 3'h0;
      pinSyncB <= 3'h0;
    end
    else
    begin
      pinSyncA <= {writeProtect, device_select_pins};
      pinSyncB <= pinSyncA;
    end
  end

  assign selSync = pinSyncB[1:0];
  assign wpSync  = pinSyncB[2];

  // ==========================================================================
  // Bus conditions
  // Data moving while the clock is high marks a start or a stop
  assign startSeen = sdaFall && sclLevel;
  assign stopSeen  = sdaRise && sclLevel;
  assign active    = (state != ST_IDLE) && (state != ST_IGNORE);
  assign byteDone  = sclRise && active && (bitCnt == BIT_LAST);
  assign ackClock  = sclRise && active && (bitCnt == BIT_ACK);
  assign rxByte    = {rxShift[DATA_W-2:0], sdaLevel};

  // ==========================================================================
  // Protocol engine: next values
  always_comb
  begin
    next_state       = state;
    next_bitCnt      = bitCnt;
    next_rxShift     = rxShift;
    next_txShift     = txShift;
    next_addr        = addr;
    next_addrHi      = addrHi;
    next_page        = page;
    next_firstRead   = firstRead;
    next_drive       = drive;
    next_driveEnable = driveEnable;
    memWe            = 1'b0;
    if (startSeen)
    begin
      // Abort whatever runs and expect a slave byte
      next_state       = ST_SLAVE;
      next_bitCnt      = BIT_FIRST;
      next_drive       = 1'b0;
      next_driveEnable = 1'b0;
    end
    else if (stopSeen)
    begin
      next_state       = ST_IDLE;
      next_bitCnt      = BIT_FIRST;
      next_drive       = 1'b0;
      next_driveEnable = 1'b0;
    end
    else if (ackClock)
    begin
      next_bitCnt = BIT_FIRST;
      next_drive  = 1'b0;
      if (state == ST_READ)
      begin
        // Our own acknowledge, or the master's, starts the next byte
        if (firstRead || !sdaLevel)
        begin
          next_txShift   = readData;
          next_drive     = !readData[DATA_W-1];
          next_firstRead = 1'b0;
        end
        else
        begin
          next_state = ST_IDLE;
        end
      end
    end
    else if (sclRise && active)
    begin
      next_rxShift = rxByte;
      next_bitCnt  = bitCnt + 4'h1;
      if (state == ST_READ)
      begin
        if (bitCnt == BIT_LAST)
        begin
          next_drive = 1'b0;
          next_addr  = addr + ADDR_W'(1);
        end
        else
        begin
          next_drive   = !txShift[DATA_W-2];
          next_txShift = {txShift[DATA_W-2:0], 1'b0};
        end
      end
      else if (bitCnt == BIT_LAST)
      begin
        next_drive = 1'b1;
        case (state)
          ST_SLAVE:
          begin
            if (rxByte[TYPE_MSB:TYPE_LSB] == SLAVE_TYPE &&
                rxByte[SEL_MSB:SEL_LSB] == selSync)
            begin
              next_page      = rxByte[PAGE_BIT];
              next_firstRead = rxByte[RW_BIT];
              next_state     = rxByte[RW_BIT] ? ST_READ : ST_ADDRHI;
            end
            else
            begin
              next_drive = 1'b0;
              next_state = ST_IGNORE;
            end
          end
          ST_ADDRHI:
          begin
            next_addrHi = rxByte;
            next_state  = ST_ADDRLO;
          end
          ST_ADDRLO:
          begin
            next_addr  = {page, addrHi, rxByte};
            next_state = ST_WRITE;
          end
          ST_WRITE:
          begin
            memWe     = !wpSync;
            next_addr = addr + ADDR_W'(1);
          end
          default:
          begin
            next_drive = 1'b0;
          end
        endcase
      end
    end
    // Enable the pin only once the link flop has taken a fresh value
    if (!startSeen && !stopSeen && sclRise == 1'b0 && !sclLevel)
    begin
      next_driveEnable = active;
    end
  end

  // Protocol engine: registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state       <= ST_IDLE;
      bitCnt      <= BIT_FIRST;
      rxShift     <= '0;
      txShift     <= '0;
      addr        <= '0;
      addrHi      <= '0;
      page        <= 1'b0;
      firstRead   <= 1'b0;
      drive       <= 1'b0;
      driveEnable <= 1'b0;
      deviceId    <= DEVICE_ID;
    end
    else
    begin
      state       <= next_state;
      bitCnt      <= next_bitCnt;
      rxShift     <= next_rxShift;
      txShift     <= next_txShift;
      addr        <= next_addr;
      addrHi      <= next_addrHi;
      page        <= next_page;
      firstRead   <= next_firstRead;
      drive       <= next_drive;
      driveEnable <= next_driveEnable;
      deviceId    <= DEVICE_ID;
    end
  end

  // ==========================================================================
  // Byte array; the write lands in the cycle the byte completes
  always_ff @(posedge core_clk)
  begin
    if (memWe)
    begin
      mem[addr] <= rxByte;
    end
    readData <= mem[addr];
  end

  // ==========================================================================
  // Link side: the pull level changes only on the falling serial clock.
  // drive settles early in the high phase and holds across the fall, so the
  // bus protocol itself acts as the handshake for this crossing.
  always_ff @(negedge serialClk)
  begin
    linkPull <= drive;
  end

  // Open drain: never drives high, core gate ends it at start or stop
  assign sdaOut = 1'b0;
  assign sdaOe  = linkPull && driveEnable;

  // ==========================================================================
  // Checks
  a_select_miss: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_SLAVE && byteDone && !startSeen && !stopSeen &&
     rxByte[SEL_MSB:SEL_LSB] != selSync) |=> (state == ST_IGNORE && !drive))
    else $error("slave byte with other select bits was not ignored");

  a_select_ack: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_SLAVE && byteDone && !startSeen && !stopSeen &&
     rxByte == {SLAVE_TYPE, selSync, 2'b00}) |=> (drive && state == ST_ADDRHI))
    else $error("matching write slave byte not acknowledged");

  a_protect_block: assert property (@(posedge core_clk) disable iff (reset)
    wpSync |-> !memWe)
    else $error("array written while write protect high");

  a_write_open: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_WRITE && byteDone && !wpSync && !startSeen && !stopSeen) |-> memWe)
    else $error("unprotected data byte not written");

  a_addr_step: assert property (@(posedge core_clk) disable iff (reset)
    memWe |=> (addr == ADDR_W'($past(addr) + ADDR_W'(1))))
    else $error("address did not step after a write");

  a_addr_load: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_ADDRLO && byteDone && !startSeen && !stopSeen)
    |=> (addr == {$past(page), $past(addrHi), $past(rxByte)} && state == ST_WRITE))
    else $error("address not loaded from page and two bytes");

  a_start_abort: assert property (@(posedge core_clk) disable iff (reset)
    startSeen |=> (state == ST_SLAVE && bitCnt == BIT_FIRST && !sdaOe))
    else $error("start did not restart the slave");

  a_stop_abort: assert property (@(posedge core_clk) disable iff (reset)
    stopSeen |=> (state == ST_IDLE && !sdaOe) ##1 !sdaOe)
    else $error("stop did not release the bus");

  a_nack_end: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_READ && ackClock && !firstRead && sdaLevel && !startSeen && !stopSeen)
    |=> (state == ST_IDLE && !drive))
    else $error("read continued after master withheld acknowledge");

  a_low_only: assert property (@(posedge core_clk) disable iff (reset)
    sdaOe |-> (sdaOut == 1'b0 && active))
    else $error("data pin driven other than low or outside a transfer");

endmodule
`default_nettype wire

/* File: bench/i2c_master_model.sv */
// Behavioural two-wire bus master that drives the serial clock and data lines
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model
#(
  parameter int     QUARTER_NS = 200
)
(
  output var logic  scl,
  output var logic  sdaDrv,
  input  wire logic sdaLine
);
  // ==========================================================================
  // Both lines are released between frames, and the clock stands still there
  initial
  begin
    scl    = 1'h1;
    sdaDrv = 1'h1;
  end

  // Data changes only while the clock is low, so no false start or stop appears.
  // The high phase stays long because the slave filters its pins.
  task automatic putBit(input logic b);
    scl = 1'h0;
    #(QUARTER_NS);
    sdaDrv = b;
    #(QUARTER_NS);
    scl = 1'h1;
    #(2 * QUARTER_NS);
    scl = 1'h0;
  endtask

  // Release the line, then sample it in the middle of the high phase
  task automatic getBit(output logic b);
    scl    = 1'h0;
    sdaDrv = 1'h1;
    #(2 * QUARTER_NS);
    scl = 1'h1;
    #(QUARTER_NS);
    b = sdaLine;
    #(QUARTER_NS);
    scl = 1'h0;
  endtask

  // Start, also used as a repeated start or as an abort
  task automatic startCond();
    sdaDrv = 1'h1;
    #(QUARTER_NS);
    scl = 1'h1;
    #(QUARTER_NS);
    sdaDrv = 1'h0;
    #(QUARTER_NS);
    scl = 1'h0;
    #(QUARTER_NS);
  endtask

  task automatic stopCond();
    scl    = 1'h0;
    sdaDrv = 1'h0;
    #(QUARTER_NS);
    scl = 1'h1;
    #(QUARTER_NS);
    sdaDrv = 1'h1;
    #(2 * QUARTER_NS);
  endtask

  // Byte out, most significant bit first; ack is high when the slave pulled low
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      putBit(d[i]);
    getBit(b);
    ack = ~b;
  endtask

  // Byte in; the last wanted byte is answered with a withheld acknowledge
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      getBit(d[i]);
    putBit(~ackIt);
  endtask
endmodule
`default_nettype wire

/* File: bench/serial_fram_i2c_slave_test.sv */
// Self-checking testbench for the two-wire serial memory slave
`timescale 1ns/100ps
`default_nettype none
module serial_fram_i2c_slave_test;
  import serial_fram_pkg::*;

  localparam logic [23:0] ID_VALUE = 24'h2b71c4;  // Arbitrary value

  typedef struct packed
  {
    logic [1:0]  pins;
    logic [3:0]  typ;
    logic [1:0]  sel;
    logic        wp;
    logic [16:0] addr;
    logic [7:0]  data;
    logic        ack;
    logic [7:0]  exp;
  } row_t;

  // ==========================================================================
  // Ordinary cases: select match, protection, page bit, device type
  localparam row_t ROWS [7] = '{
    '{2'h1, SLAVE_TYPE, 2'h1, 1'h0, 17'h00100, 8'h77, 1'h1, 8'h77},
    '{2'h1, SLAVE_TYPE, 2'h3, 1'h0, 17'h00100, 8'h11, 1'h0, 8'h77},
    '{2'h3, SLAVE_TYPE, 2'h3, 1'h1, 17'h00100, 8'h22, 1'h1, 8'h77},
    '{2'h0, SLAVE_TYPE, 2'h0, 1'h0, 17'h00012, 8'ha5, 1'h1, 8'ha5},
    '{2'h2, SLAVE_TYPE, 2'h2, 1'h0, 17'h10012, 8'h3c, 1'h1, 8'h3c},
    '{2'h0, SLAVE_TYPE, 2'h1, 1'h0, 17'h00012, 8'hff, 1'h0, 8'ha5},
    '{2'h0, 4'hb,       2'h0, 1'h0, 17'h00012, 8'hff, 1'h0, 8'ha5}};

  logic        core_clk;
  logic        reset;
  logic        scl;
  logic        sdaDrv;
  logic        sdaOut;
  logic        sdaOe;
  logic        writeProtect;
  logic        ok;
  logic [1:0]  pins;
  logic [23:0] deviceId;
  logic [7:0]  got [2];
  wire logic   sdaLine;
  int          fail_count;
  int          samples_checked;

  // Pull-up on the data line, wire-AND of both parties
  assign sdaLine = sdaDrv & ~sdaOe;

  serial_fram_slave #(.DEVICE_ID(ID_VALUE)) dut_u
  (
    .core_clk           (core_clk),
    .reset              (reset),
    .serialClk          (scl),
    .sclIn              (scl),
    .sdaIn              (sdaLine),
    .sdaOut             (sdaOut),
    .sdaOe              (sdaOe),
    .device_select_pins (pins),
    .writeProtect       (writeProtect),
    .deviceId           (deviceId)
  );

  i2c_master_model master_u
  (
    .scl     (scl),
    .sdaDrv  (sdaDrv),
    .sdaLine (sdaLine)
  );

  initial core_clk = 1'h0;
  always #10 core_clk = ~core_clk;

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [23:0] gotV, input logic [23:0] expV, input string msg);
    samples_checked++;
    if (gotV !== expV)
    begin
      fail_count++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Slave byte, then the two address bytes of a write
  task automatic setAddr(input logic [3:0] typ, input logic [1:0] sel,
                         input logic [16:0] a, output logic ack);
    logic dummy;
    master_u.startCond();
    master_u.writeByte({typ, sel, a[16], 1'h0}, ack);
    if (ack)
    begin
      master_u.writeByte(a[15:8], dummy);
      master_u.writeByte(a[7:0], dummy);
    end
  endtask

  task automatic writeAt(input logic [3:0] typ, input logic [1:0] sel, input logic [16:0] a,
                         input int n, input logic [7:0] d0, input logic [7:0] d1,
                         output logic ack);
    logic dummy;
    setAddr(typ, sel, a, ack);
    for (int i = 0; i < n && ack; i++)
      master_u.writeByte(i == 0 ? d0 : d1, dummy);
    master_u.stopCond();
  endtask

  // Load the address, then a repeated start and a read from the current address
  task automatic readAt(input logic [16:0] a, input int n);
    logic ack;
    setAddr(SLAVE_TYPE, pins, a, ack);
    master_u.startCond();
    master_u.writeByte({SLAVE_TYPE, pins, a[16], 1'h1}, ack);
    for (int i = 0; i < n; i++)
      master_u.readByte(i < n - 1, got[i]);
    master_u.stopCond();
  endtask

  // ==========================================================================
  // Line monitors: open-drain output, changes only while the clock is low
  always @(posedge core_clk)
    if (reset === 1'h0 && sdaOe === 1'h1)
      check(sdaOut, 1'h0, "data line driven high");

  always @(sdaOe)
    if (reset === 1'h0)
      check(scl, 1'h0, "data output moved while clock high");

  initial
  begin
    #1500000;
    fail_count++;
    $display("unexpected at %0t ns: run did not finish", $time);
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    reset        = 1'h1;
    pins         = 2'h0;
    writeProtect = 1'h0;
    fail_count      = 0;
    samples_checked = 0;
    repeat (3) @(posedge core_clk);
    #2;
    check(sdaOe, 1'h0, "data line driven in reset");
    check(deviceId, ID_VALUE, "identification value");
    reset = 1'h0;
    repeat (10) @(posedge core_clk);
    $display("reset test done");

    foreach (ROWS[i])
    begin
      @(posedge core_clk);
      #2;
      pins         = ROWS[i].pins;
      writeProtect = ROWS[i].wp;
      writeAt(ROWS[i].typ, ROWS[i].sel, ROWS[i].addr, 1, ROWS[i].data, 8'h00, ok);
      check(ok, ROWS[i].ack, "slave byte acknowledge");
      @(posedge core_clk);
      #2;
      writeProtect = 1'h0;
      readAt(ROWS[i].addr, 1);
      check(got[0], ROWS[i].exp, "stored byte");
      $display("row %0d done", i);
    end

    // Two bytes across the top of the array, read straight back without polling
    @(posedge core_clk);
    #2;
    pins = 2'h0;
    writeAt(SLAVE_TYPE, pins, 17'h1ffff, 2, 8'h5e, 8'he5, ok);
    readAt(17'h1ffff, 2);
    check(got[0], 8'h5e, "last location");
    check(got[1], 8'he5, "wrapped read");
    readAt(17'h00000, 1);
    check(got[0], 8'he5, "wrapped write");
    $display("wrap test done");

    // Data byte cut short by a start; the location keeps its old value
    setAddr(SLAVE_TYPE, pins, 17'h00012, ok);
    for (int i = 0; i < 4; i++)
      master_u.putBit(1'h0);
    master_u.startCond();
    master_u.stopCond();
    readAt(17'h00012, 1);
    check(got[0], 8'ha5, "aborted byte stored");
    $display("abort test done");
    end_of_test();
  end
endmodule
`default_nettype wire
